// ### csel_clock_select.sv
/*
 * Dual oscillator clock select: register file, enable interlocks, glitch-free
 * source switch, speed divider, timer-0 subclock tap and oscillator power controls.
 * It assumes oscillator ticks and the timer-0 pin are synchronous to ref_clk, and
 * that the low-power controller holds the idle and power-down levels while in a mode.
 */
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module csel_clock_select (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic oscSelectFuse,
    input wire logic speedFuse,
    input wire logic secondaryExtClock,
    input wire logic idleMode,
    input wire logic powerDownMode,
    input wire logic primaryOscTick,
    input wire logic secondaryOscTick,
    input wire logic timer0CountPin,
    output logic sysClkTick,
    output logic sysClkLevel,
    output logic timer0CountIn,
    output logic primaryOscRun,
    output logic secondaryOscRun,
    output logic secondaryAmpEnable,
    output logic secondaryInPinGpio,
    output logic secondaryOutPinGpio,
    output logic switchBusy
);

    typedef struct packed {
        logic sourceSelect;
        logic primaryEn;
        logic secondaryEn;
        logic subclock;
        logic speed;
        logic activeSource;
        logic targetSource;
        csel_pkg::csel_sw_state_t sw;
        logic timer0In;
        logic [7:0] rdata;
    } csel_state_t;

    csel_state_t state_q;
    csel_state_t state_d;

    logic lowPower;
    logic primaryTick;
    logic secondaryTick;
    logic oldTick;
    logic newTick;
    logic gatedTick;
    logic subTickLevel;
    logic speedTick;
    logic speedLevel;

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding shared by the read and the write path, and the source pick used by the mux and the switch sequencer.
    function automatic logic csel_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        csel_hit = (addr == reg_addr);
    endfunction

    function automatic logic csel_pick(input logic src, input logic prim, input logic sec);
        csel_pick = (src == csel_pkg::CSEL_SRC_PRIMARY) ? prim : sec;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator run controls and pin release.
    assign lowPower = idleMode | powerDownMode;
    assign primaryOscRun = state_q.primaryEn & ~powerDownMode;
    assign secondaryOscRun = state_q.secondaryEn & ~powerDownMode;
    assign secondaryAmpEnable = secondaryOscRun & ~secondaryExtClock;
    assign secondaryInPinGpio = ~state_q.secondaryEn;
    assign secondaryOutPinGpio = ~state_q.secondaryEn | secondaryExtClock;

    // A stopped oscillator delivers no ticks.
    assign primaryTick = primaryOscTick & primaryOscRun;
    assign secondaryTick = secondaryOscTick & secondaryOscRun;

    ////////////////////////////////////////////////////////////////////////////////
    // Only the active source passes, and nothing passes while a switch is under way,
    // so the system clock never sees a mix of both or a shortened period.
    assign oldTick = csel_pick(state_q.activeSource, primaryTick, secondaryTick);
    assign newTick = csel_pick(state_q.targetSource, primaryTick, secondaryTick);
    assign gatedTick = (state_q.sw == csel_pkg::CSEL_SW_RUN) ? oldTick : 1'b0;
    assign switchBusy = (state_q.sw != csel_pkg::CSEL_SW_RUN);

    ////////////////////////////////////////////////////////////////////////////////
    // Speed divider sits after the source mux, so it serves either oscillator.
    csel_tick_div #(
        .DIV(csel_pkg::CSEL_SPEED_DIV)
    ) u_speed_div (
        .ref_clk(ref_clk),
        .srst(srst),
        .tickIn(gatedTick),
        .bypass(state_q.speed),
        .tickOut(speedTick),
        .levelOut(speedLevel)
    );

    // Subclock tap runs on the secondary oscillator whatever source is selected.
    csel_tick_div #(
        .DIV(csel_pkg::CSEL_SUBCLOCK_DIV)
    ) u_sub_div (
        .ref_clk(ref_clk),
        .srst(srst),
        .tickIn(secondaryTick),
        .bypass(1'b0),
        .tickOut(),
        .levelOut(subTickLevel)
    );

    assign sysClkTick = speedTick;
    assign sysClkLevel = speedLevel;
    assign timer0CountIn = state_q.timer0In;

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes, interlocks, switch sequencer and read data.
    always_comb begin
        state_d = state_q;
        state_d.rdata = csel_pkg::CSEL_RST_RDATA;
        // The subclock square wave is valid only while the secondary oscillator runs.
        state_d.timer0In = state_q.subclock ? subTickLevel : timer0CountPin;

        if (regWrite) begin
            if (csel_hit(regAddr, csel_pkg::CSEL_ADDR_SOURCE_SELECT)) begin
                // The request is taken as soon as the target is enabled; settling is
                // left to software.
                if (!lowPower) begin
                    if (regWdata[csel_pkg::CSEL_BIT_SELECT] == csel_pkg::CSEL_SRC_PRIMARY) begin
                        if (state_q.primaryEn) begin
                            state_d.sourceSelect = csel_pkg::CSEL_SRC_PRIMARY;
                        end
                    end else begin
                        if (state_q.secondaryEn) begin
                            state_d.sourceSelect = csel_pkg::CSEL_SRC_SECONDARY;
                        end
                    end
                end
            end
            if (csel_hit(regAddr, csel_pkg::CSEL_ADDR_OSC_CONTROL)) begin
                // Clearing the enable of the selected source is ignored.
                state_d.primaryEn = regWdata[csel_pkg::CSEL_BIT_PRIMARY_EN]
                    | (state_q.sourceSelect == csel_pkg::CSEL_SRC_PRIMARY);
                state_d.secondaryEn = regWdata[csel_pkg::CSEL_BIT_SECONDARY_EN]
                    | (state_q.sourceSelect == csel_pkg::CSEL_SRC_SECONDARY);
                state_d.subclock = regWdata[csel_pkg::CSEL_BIT_SUBCLOCK];
            end
            if (csel_hit(regAddr, csel_pkg::CSEL_ADDR_CLOCK_CONTROL0)) begin
                state_d.speed = regWdata[csel_pkg::CSEL_BIT_SPEED];
            end
        end

        if (regRead) begin
            if (csel_hit(regAddr, csel_pkg::CSEL_ADDR_SOURCE_SELECT)) begin
                state_d.rdata[csel_pkg::CSEL_BIT_SELECT] = state_q.sourceSelect;
                state_d.rdata[csel_pkg::CSEL_BIT_BUSY] = switchBusy;
            end
            if (csel_hit(regAddr, csel_pkg::CSEL_ADDR_OSC_CONTROL)) begin
                state_d.rdata[csel_pkg::CSEL_BIT_PRIMARY_EN] = state_q.primaryEn;
                state_d.rdata[csel_pkg::CSEL_BIT_SECONDARY_EN] = state_q.secondaryEn;
                state_d.rdata[csel_pkg::CSEL_BIT_SUBCLOCK] = state_q.subclock;
            end
            if (csel_hit(regAddr, csel_pkg::CSEL_ADDR_CLOCK_CONTROL0)) begin
                state_d.rdata[csel_pkg::CSEL_BIT_SPEED] = state_q.speed;
            end
        end

        // Gate off as the switch starts, wait for the old source's tick, then open on the new source's tick:
        // at most one period of each, well inside two.
        unique case (state_q.sw)
            csel_pkg::CSEL_SW_RUN: begin
                if (state_q.sourceSelect != state_q.activeSource) begin
                    state_d.targetSource = state_q.sourceSelect;
                    state_d.sw = csel_pkg::CSEL_SW_DRAIN;
                end
            end
            csel_pkg::CSEL_SW_DRAIN: begin
                // A source that software has already disabled has no edge left to wait
                // for, so the drain ends at once rather than stalling the switch.
                if (oldTick
                    || !csel_pick(state_q.activeSource, state_q.primaryEn, state_q.secondaryEn)) begin
                    state_d.sw = csel_pkg::CSEL_SW_ARM;
                end
            end
            csel_pkg::CSEL_SW_ARM: begin
                if (newTick) begin
                    state_d.activeSource = state_q.targetSource;
                    state_d.sw = csel_pkg::CSEL_SW_RUN;
                end
            end
            default: begin
                state_d.sw = csel_pkg::CSEL_SW_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q.sourceSelect <= oscSelectFuse;
            state_q.primaryEn <= oscSelectFuse;
            state_q.secondaryEn <= ~oscSelectFuse;
            state_q.subclock <= csel_pkg::CSEL_RST_SUBCLOCK;
            state_q.speed <= ~speedFuse;
            state_q.activeSource <= oscSelectFuse;
            state_q.targetSource <= oscSelectFuse;
            state_q.sw <= csel_pkg::CSEL_SW_RUN;
            state_q.timer0In <= 1'b0;
            state_q.rdata <= csel_pkg::CSEL_RST_RDATA;
        end else begin
            state_q <= state_d;
        end
    end

    assign regRdata = state_q.rdata;

endmodule

// ### csel_clock_select_sva.sv
/*
 * Checker for the clock select block, bound to its top module.
 * It assumes the oscillators tick at most every 10 cycles while a switch runs.
 */
`timescale 1ns/1ps
module csel_checker (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic powerDownMode,
    input wire logic secondaryExtClock,
    input wire logic sysClkTick,
    input wire logic sysClkLevel,
    input wire logic primaryOscRun,
    input wire logic secondaryOscRun,
    input wire logic secondaryAmpEnable,
    input wire logic secondaryInPinGpio,
    input wire logic secondaryOutPinGpio,
    input wire logic switchBusy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    pd_stop_a: assert property (powerDownMode |-> !primaryOscRun && !secondaryOscRun)
        else $error("oscillator runs in power-down");
    pd_tick_a: assert property (powerDownMode && $past(powerDownMode) |-> !sysClkTick)
        else $error("system tick in power-down");
    amp_off_a: assert property (secondaryExtClock || !secondaryOscRun |-> !secondaryAmpEnable)
        else $error("secondary amplifier on");
    out_gpio_a: assert property (secondaryExtClock |-> secondaryOutPinGpio)
        else $error("secondary out pin not freed");
    pin_free_a: assert property (!powerDownMode |-> secondaryInPinGpio == !secondaryOscRun)
        else $error("secondary in pin state wrong");
    busy_gate_a: assert property (switchBusy && $past(switchBusy) |-> !sysClkTick)
        else $error("system tick during switch");
    switch_bound_a: assert property ($rose(switchBusy) |-> ##[1:30] !switchBusy)
        else $error("switch too slow");
    level_toggle_a: assert property (sysClkTick |-> sysClkLevel != $past(sysClkLevel))
        else $error("system level did not toggle");
    reset_clear_a: assert property ($fell(srst) |-> regRdata == 8'h00 && !switchBusy)
        else $error("reset state wrong");
    rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 8'h00)
        else $error("read data outside answer cycle");
    cover property ($rose(switchBusy));
    cover property (powerDownMode);
    cover property (sysClkTick && !switchBusy);
endmodule
bind csel_clock_select csel_checker u_chk (.ref_clk(ref_clk), .srst(srst), .regRead(regRead),
    .regRdata(regRdata), .powerDownMode(powerDownMode), .secondaryExtClock(secondaryExtClock),
    .sysClkTick(sysClkTick), .sysClkLevel(sysClkLevel), .primaryOscRun(primaryOscRun),
    .secondaryOscRun(secondaryOscRun), .secondaryAmpEnable(secondaryAmpEnable),
    .secondaryInPinGpio(secondaryInPinGpio), .secondaryOutPinGpio(secondaryOutPinGpio),
    .switchBusy(switchBusy));

// ### csel_osc_model.sv
/*
 * Oscillator partner model: one tick pulse every PER ref_clk cycles while running.
 * It assumes run comes from the block's run output for the same oscillator.
 */
`timescale 1ns/1ps
module csel_osc_model #(
    parameter int PER = 4
) (
    input wire logic ref_clk,
    input wire logic run,
    output logic tick
);
    int cnt = 0;
    // A stopped oscillator holds its phase and sends no ticks, like a real one.
    always @(posedge ref_clk) begin
        if (run) begin
            cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
        end
    end
    assign tick = run && (cnt == PER - 1);
endmodule

// ### csel_pkg.sv
/*
 * Constants, register map and types shared by the dual oscillator clock select block.
 * It assumes that both oscillators and the timer-0 count pin reach the block as
 * one-cycle tick pulses or levels that are synchronous to ref_clk.
 */
// Operation
// - Select bit zero picks secondary, one primary.
// - Reset loads enables and select from fuse.
// - Exactly one oscillator drives system clock. In the code neither one drives it while a switch is under way.
// - Switch completes within two periods each oscillator.
// - Selected oscillator's enable cannot be cleared.
// - Never switch toward a disabled oscillator.
// - No stability check before switching.
// - Idle keeps enabled oscillators running.
// - No source change during idle or power-down.
// - Power-down stops all oscillators.
// - Interrupt exit keeps enables and select unchanged.
// - Any reset restores fuse defaults, leaves low power.
// - Timer-0 input from pin or secondary divided 128.
// - Disabled oscillator powers down, secondary pins freed.
// - External secondary clock turns amplifier off.
// - Speed bit zero divides by two, even duty.
// - Speed bit one passes oscillator straight through.
// - Speed bit resets to inverse of its fuse.
// - Speed divider applies to both oscillators.
package csel_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map.
    localparam logic [7:0] CSEL_ADDR_SOURCE_SELECT = 8'h85;
    localparam logic [7:0] CSEL_ADDR_OSC_CONTROL = 8'h86;
    localparam logic [7:0] CSEL_ADDR_CLOCK_CONTROL0 = 8'h8f;

    // Field positions.
    localparam int CSEL_BIT_SELECT = 0;
    localparam int CSEL_BIT_BUSY = 7;
    localparam int CSEL_BIT_PRIMARY_EN = 0;
    localparam int CSEL_BIT_SECONDARY_EN = 1;
    localparam int CSEL_BIT_SUBCLOCK = 2;
    localparam int CSEL_BIT_SPEED = 0;

    // Reset values of controls that no fuse sets.
    localparam logic CSEL_RST_SUBCLOCK = 1'b0;
    localparam logic [7:0] CSEL_RST_RDATA = 8'h00;

    // Source codes of the select bit.
    localparam logic CSEL_SRC_SECONDARY = 1'b0;
    localparam logic CSEL_SRC_PRIMARY = 1'b1;

    // Division ratios.
    localparam int CSEL_SPEED_DIV = 2;
    localparam int CSEL_SUBCLOCK_DIV = 128;

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        CSEL_SW_RUN = 2'b00,
        CSEL_SW_DRAIN = 2'b01,
        CSEL_SW_ARM = 2'b10
    } csel_sw_state_t;

endpackage

// ### csel_tick_div.sv
/*
 * Tick divider: passes every DIV-th input tick as an output tick and toggles a
 * square level every DIV/2 input ticks, or passes ticks straight when bypassed.
 * It assumes input ticks are single ref_clk cycles and DIV is even and at least two.
 */
`timescale 1ns/1ps
module csel_tick_div #(
    parameter int DIV = 2
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic tickIn,
    input wire logic bypass,
    output logic tickOut,
    output logic levelOut
);

    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] HALF = CW'(DIV / 2 - 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic level;
        logic tick;
    } csel_div_state_t;

    csel_div_state_t state_q;
    csel_div_state_t state_d;

    ////////////////////////////////////////////////////////////////////////////////
    // The level toggles on the half-way and on the final count, so it has an even duty
    // cycle when the input ticks are evenly spaced.
    always_comb begin
        state_d = state_q;
        state_d.tick = 1'b0;
        if (tickIn) begin
            if (bypass) begin
                state_d.tick = 1'b1;
                state_d.level = ~state_q.level;
                state_d.count = '0;
            end else if (state_q.count == LAST) begin
                state_d.count = '0;
                state_d.tick = 1'b1;
                state_d.level = ~state_q.level;
            end else begin
                state_d.count = state_q.count + CW'(1);
                if (state_q.count == HALF) begin
                    state_d.level = ~state_q.level;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign tickOut = state_q.tick;
    assign levelOut = state_q.level;

endmodule

// ### tb_csel_clock_select.sv
/*
 * Self-checking testbench for the clock select block with two oscillator models.
 * It assumes a primary period of 4 and a secondary period of 10 ref_clk cycles.
 */
`timescale 1ns/1ps
module tb_csel_clock_select;
    logic ref_clk = 1'b0, srst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00;
    logic oscSelectFuse = 1'b1, speedFuse = 1'b1, secondaryExtClock = 1'b0;
    logic idleMode = 1'b0, powerDownMode = 1'b0, timer0CountPin = 1'b0;
    logic [7:0] regRdata;
    logic priTick, secTick, sysClkTick, sysClkLevel, timer0CountIn, primaryOscRun;
    logic secondaryOscRun, secondaryAmpEnable, secondaryInPinGpio, secondaryOutPinGpio;
    logic switchBusy;
    int fail_count = 0, samples_checked = 0;
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    csel_clock_select DUT (.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .oscSelectFuse(oscSelectFuse), .speedFuse(speedFuse),
        .secondaryExtClock(secondaryExtClock), .idleMode(idleMode),
        .powerDownMode(powerDownMode), .primaryOscTick(priTick), .secondaryOscTick(secTick),
        .timer0CountPin(timer0CountPin), .sysClkTick(sysClkTick), .sysClkLevel(sysClkLevel),
        .timer0CountIn(timer0CountIn), .primaryOscRun(primaryOscRun),
        .secondaryOscRun(secondaryOscRun), .secondaryAmpEnable(secondaryAmpEnable),
        .secondaryInPinGpio(secondaryInPinGpio), .secondaryOutPinGpio(secondaryOutPinGpio),
        .switchBusy(switchBusy));
    csel_osc_model #(.PER(4)) u_pri (.ref_clk(ref_clk), .run(primaryOscRun), .tick(priTick));
    csel_osc_model #(.PER(10)) u_sec (.ref_clk(ref_clk), .run(secondaryOscRun), .tick(secTick));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic note(input bit bad);
        samples_checked++;
        if (bad) begin
            fail_count++;
            $display("CHECK FAILED at %0t: unexpected result", $time);
        end
    endtask
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        note(g !== e);
    endtask
    task automatic cmp1(input logic g, input logic e);
        note(g !== e);
    endtask
    task automatic cmpn(input int g, input int e);
        note(g != e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        cmp8(regRdata, e);
    endtask
    task automatic rst(input logic f, input logic s);
        oscSelectFuse <= f;
        speedFuse <= s;
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
    endtask
    // Bounded so that a dead clock path shows as a wrong count, not a hang.
    task automatic wait_ev(input bit useT0, output int k);
        logic last;
        last = timer0CountIn;
        for (k = 1; k < 2000; k++) begin
            @(posedge ref_clk);
            #1;
            if (useT0 ? (timer0CountIn !== last) : (sysClkTick === 1'b1)) break;
        end
    endtask
    task automatic gap(input bit useT0, input int e);
        int k;
        wait_ev(useT0, k);
        if (useT0) wait_ev(useT0, k);
        wait_ev(useT0, k);
        cmpn(k, e);
    endtask
    task automatic settle;
        repeat (2) @(posedge ref_clk);
        #1;
        for (int i = 0; i < 100 && switchBusy !== 1'b0; i++) begin
            @(posedge ref_clk);
            #1;
        end
        cmp1(switchBusy, 1'b0);
    endtask
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst(1'b1, 1'b1);
        rdc(8'h85, 8'h01);
        rdc(8'h86, 8'h01);
        rdc(8'h8f, 8'h00);
        wr(8'h86, 8'h00);
        rdc(8'h86, 8'h01);
        wr(8'h85, 8'h00);
        rdc(8'h85, 8'h01);
        wr(8'h90, 8'hff);
        rdc(8'h90, 8'h00);
        wr(8'h86, 8'h03);
        powerDownMode <= 1'b1;
        wr(8'h85, 8'h00);
        rdc(8'h85, 8'h01);
        cmp1(primaryOscRun, 1'b0);
        cmp1(secondaryOscRun, 1'b0);
        @(posedge ref_clk);
        powerDownMode <= 1'b0;
        idleMode <= 1'b1;
        wr(8'h85, 8'h00);
        rdc(8'h85, 8'h01);
        cmp1(primaryOscRun, 1'b1);
        cmp1(secondaryOscRun, 1'b1);
        @(posedge ref_clk);
        idleMode <= 1'b0;
        rdc(8'h86, 8'h03);
        wr(8'h85, 8'h00);
        settle();
        rdc(8'h85, 8'h00);
        gap(1'b0, 20);
        wr(8'h86, 8'h02);
        wr(8'h86, 8'h00);
        rdc(8'h86, 8'h02);
        wr(8'h8f, 8'h01);
        gap(1'b0, 10);
        wr(8'h86, 8'h06);
        gap(1'b1, 640);
        wr(8'h86, 8'h02);
        repeat (2) @(posedge ref_clk);
        #1;
        cmp1(timer0CountIn, 1'b0);
        @(posedge ref_clk);
        timer0CountPin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        cmp1(timer0CountIn, 1'b1);
        wr(8'h86, 8'h03);
        wr(8'h85, 8'h01);
        settle();
        gap(1'b0, 4);
        @(posedge ref_clk);
        secondaryExtClock <= 1'b1;
        @(posedge ref_clk);
        #1;
        cmp1(secondaryAmpEnable, 1'b0);
        cmp1(secondaryOutPinGpio, 1'b1);
        wr(8'h86, 8'h01);
        @(posedge ref_clk);
        #1;
        cmp1(secondaryInPinGpio, 1'b1);
        @(posedge ref_clk);
        rst(1'b0, 1'b0);
        rdc(8'h85, 8'h00);
        rdc(8'h86, 8'h02);
        rdc(8'h8f, 8'h01);
        test_done();
    end
endmodule
